// File: core_rail_fault_alert.sv
// Core rail thermal/current alerts, over-current and over-voltage protection
// Function
// - Thermal zone bit 6 set drives attention low and sets status bit 1.
// - Thermal alert and status bit 1 clear only when zone bit 5 falls.
// - Status bit 1 follows thermal alert unlatched; reads never clear it.
// - Thermal zone top bit set pulls thermal-hot output low.
// - Thermal-hot releases only when zone bit 6 falls from one to zero.
// - Thermal-hot is open-drain active low, pulling low only.
// - Load current code is eight bits, stored for host reading.
// - Full-scale current code drives attention low and sets status bit 2.
// - Maximum-current alert releases once current code falls to 242.
// - Status bit 2 latched; clears on status read after current at 242.
// - Quick response pulse overrides on-time of every active phase.
// - Phase over limit has its high-side gate forced off meanwhile.
// - Fifteen over-limit switching cycles set latch, phase drives high-Z.
// - Over-current counter returns to zero when condition breaks early.
// - Over-current latch starts graphics rail soft shutdown.
// - Output above max code plus 150mV (850mV with offset strap high) latches over-voltage, low sides on.
// - Over-voltage must persist through a 1us filter before latching.
// - Over-voltage latch starts graphics rail soft shutdown.
// - Over-voltage monitoring starts only after power-on reset completes.
// - Thermal zone is an eight-bit thermometer code of successive thresholds.
//
// Chosen here: the Avalon-MM interface to the registers and the register addresses.
`timescale 1ns/1ps
`default_nettype none

module core_rail_fault_alert #(
   parameter int NUM_PHASES = 3
) (
   input  wire logic                  ref_clk_i,
   input  wire logic                  rst_i,
   // Avalon-MM slave
   input  wire logic [4:0]            avs_address_i,
   input  wire logic                  avs_read_i,
   input  wire logic                  avs_write_i,
   input  wire logic [31:0]           avs_writedata_i,
   input  wire logic [3:0]            avs_byteenable_i,
   output logic      [31:0]           avs_readdata_o,
   output logic                       avs_waitrequest_o,
   // Digitised sense inputs
   input  wire logic [7:0]            temp_zone_code_i,
   input  wire logic                  current_sample_valid_i,
   input  wire logic [7:0]            current_monitor_code_i,
   input  wire logic [7:0]            phase1_sense_neg_code_i,
   input  wire logic                  offset_pin_high_i,
   // Phase control inputs
   input  wire logic                  switch_cycle_i,
   input  wire logic [NUM_PHASES-1:0] phase_active_i,
   input  wire logic [NUM_PHASES-1:0] on_time_req_i,
   input  wire logic                  quick_pulse_i,
   input  wire logic [NUM_PHASES-1:0] over_limit_i,
   // Phase drive outputs
   output logic      [NUM_PHASES-1:0] high_side_gate_o,
   output logic      [NUM_PHASES-1:0] low_side_gate_o,
   output logic      [NUM_PHASES-1:0] phase_drive_oe_o,
   // Alert and protection outputs
   output logic                       alert_n_o,
   output logic                       thermal_hot_n_o,
   output logic                       thermal_hot_oe_o,
   output logic                       overcurrent_latch_o,
   output logic                       overvoltage_latch_o,
   output logic                       graphics_rail_shutdown_o
);
   import core_rail_fault_alert_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // Behaviour overview
   //
   // Register bus
   //   Every access costs exactly one wait cycle. The request is seen with
   //   waitrequest high, read data is prepared in that cycle, and the access
   //   completes at the next edge with waitrequest low. Read data is zero
   //   outside the completion cycle, so a late sample reads as zero.
   //   Only the maximum voltage code is writable, through byte lane 0.
   //
   // Thermal path
   //   The zone code is a thermometer code sampled on every clock. The alert
   //   sets on the alert bit and clears only on a falling edge of the release
   //   bit, so a code that hovers near one threshold cannot toggle the line.
   //   The hot pin uses the same scheme one bit higher.
   //   The thermal status bit is the alert level itself, never latched.
   //
   // Current path
   //   The stored current code is updated on sample_valid only. Full scale
   //   sets both the alert and a sticky status bit. The alert drops at or
   //   below the release code. The sticky bit needs the alert released and
   //   a completed status read; a full-scale sample in the same cycle wins.
   //
   // Attention line
   //   Low while either alert is held, high only when both are released.
   //
   // Over-current
   //   Counted on switching-cycle pulses, not on clocks. A tick without any
   //   phase over the limit zeroes the count. The count saturates, and the
   //   latch stays until reset; with it set all drives float.
   //
   // Over-voltage
   //   The compare is armed one edge after reset release, when the offset
   //   strap is also captured for good. The condition must hold on every
   //   clock of the filter; a single clean cycle restarts the count.
   //   The latch holds high sides off and low sides on for active phases.
   //   A later over-current latch takes precedence and floats all drives.
   //
   // Graphics rail
   //   Either protection latch requests its soft shutdown on the same edge.
   //
   // Limitations
   //   The filter length is fixed by the clock rate constant; a different
   //   clock needs that constant changed. Latches clear only by reset.

   ////////////////////////////////////////////////////////////////////////////
   // Parameter check
   generate
      if (NUM_PHASES < 1 || NUM_PHASES > 8) begin : g_bad_phases
         $error("NUM_PHASES must be between 1 and 8");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////
   // State
   typedef struct packed {
      logic                  wait_b;
      logic [31:0]           rdata;
      logic [7:0]            zone;
      logic                  thermal_alert;
      logic                  hot;
      logic                  icc_alert;
      logic                  icc_status;
      logic [7:0]            cur_code;
      logic [7:0]            max_vcode;
      logic                  por_done;
      logic                  ofs_high;
      logic [3:0]            ocp_cnt;
      logic                  ocp_latch;
      logic [7:0]            ov_cnt;
      logic                  ovp_latch;
      logic                  gfx_sd;
      logic                  alert_n;
      logic [NUM_PHASES-1:0] hs;
      logic [NUM_PHASES-1:0] ls;
      logic [NUM_PHASES-1:0] oe;
   } state_t;

   state_t state_r;
   state_t state_nxt;

   logic       access_done;
   logic       status_read;
   logic [9:0] ov_limit;
   logic       ov_above;
   logic       any_over;

   ////////////////////////////////////////////////////////////////////////////
   // Next-state logic
   always_comb begin
      state_nxt   = state_r;
      // Access completes in the cycle waitrequest reads low
      access_done = (avs_read_i | avs_write_i) & ~state_r.wait_b;
      status_read = access_done & avs_read_i & (avs_address_i == FAULT_STATUS_OFS);

      // Bus handshake: one wait cycle, then a single ready cycle
      if (access_done) begin
         state_nxt.wait_b = 1'b1;
      end else if (avs_read_i | avs_write_i) begin
         state_nxt.wait_b = 1'b0;
      end

      // Read data prepared while waitrequest is high
      state_nxt.rdata = 32'h0000_0000;
      if (avs_read_i & state_r.wait_b) begin
         unique case (avs_address_i)
            FAULT_STATUS_OFS: begin
               state_nxt.rdata[THERMAL_ALERT_BIT] = state_r.thermal_alert;
               state_nxt.rdata[MAX_CURRENT_BIT]   = state_r.icc_status;
            end
            LOAD_CURRENT_OFS: state_nxt.rdata[7:0] = state_r.cur_code;
            TEMP_ZONE_OFS:    state_nxt.rdata[7:0] = state_r.zone;
            MAX_VOLTAGE_OFS:  state_nxt.rdata[7:0] = state_r.max_vcode;
            PROT_STATUS_OFS: begin
               state_nxt.rdata[PROT_OCP_BIT] = state_r.ocp_latch;
               state_nxt.rdata[PROT_OVP_BIT] = state_r.ovp_latch;
               state_nxt.rdata[PROT_OFS_BIT] = state_r.ofs_high;
               state_nxt.rdata[PROT_HOT_BIT] = state_r.hot;
               state_nxt.rdata[PROT_CNT_LSB +: 4] = state_r.ocp_cnt;
            end
            default: state_nxt.rdata = 32'h0000_0000;  // Unmapped reads as zero
         endcase
      end

      // Only the maximum voltage code is writable
      if (access_done & avs_write_i & (avs_address_i == MAX_VOLTAGE_OFS) &
          avs_byteenable_i[0]) begin
         state_nxt.max_vcode = avs_writedata_i[7:0];
      end

      state_nxt.zone = temp_zone_code_i;

      // thermal alert set and falling-edge release
      // status bit 1 is this level itself, no read clear
      if (temp_zone_code_i[ZONE_ALERT_BIT]) begin
         state_nxt.thermal_alert = 1'b1;
      end else if (state_r.zone[ZONE_RELEASE_BIT] & ~temp_zone_code_i[ZONE_RELEASE_BIT]) begin
         state_nxt.thermal_alert = 1'b0;
      end

      if (temp_zone_code_i[ZONE_HOT_BIT]) begin
         state_nxt.hot = 1'b1;
      end else if (state_r.zone[ZONE_ALERT_BIT] & ~temp_zone_code_i[ZONE_ALERT_BIT]) begin
         state_nxt.hot = 1'b0;
      end

      if (current_sample_valid_i) begin
         state_nxt.cur_code = current_monitor_code_i;
      end

      if (state_r.cur_code == CURRENT_FULL_SCALE) begin
         state_nxt.icc_alert = 1'b1;
      end else if (state_r.cur_code <= CURRENT_RELEASE) begin
         state_nxt.icc_alert = 1'b0;
      end

      // latched bit; a new full-scale event beats the read clear
      if (state_r.cur_code == CURRENT_FULL_SCALE) begin
         state_nxt.icc_status = 1'b1;
      end else if (status_read & ~state_r.icc_alert) begin
         state_nxt.icc_status = 1'b0;
      end

      state_nxt.alert_n = ~(state_nxt.thermal_alert | state_nxt.icc_alert);

      any_over = |over_limit_i;
      if (switch_cycle_i) begin
         if (!any_over) begin
            state_nxt.ocp_cnt = 4'h0;
         end else if (state_r.ocp_cnt == OCP_CYCLES - 4'h1) begin
            state_nxt.ocp_cnt   = OCP_CYCLES;
            state_nxt.ocp_latch = 1'b1;
         end else if (state_r.ocp_cnt != OCP_CYCLES) begin
            state_nxt.ocp_cnt = state_r.ocp_cnt + 4'h1;
         end
      end

      // power-on done one edge after reset release; strap caught then
      if (!state_r.por_done) begin
         state_nxt.por_done = 1'b1;
         state_nxt.ofs_high = offset_pin_high_i;
      end

      ov_limit = {2'b00, state_r.max_vcode} +
                 (state_r.ofs_high ? OV_MARGIN_OFS_CODES : OV_MARGIN_CODES);
      ov_above = state_r.por_done & ({2'b00, phase1_sense_neg_code_i} > ov_limit);

      // filter: condition must hold every cycle for the full delay
      if (!ov_above) begin
         state_nxt.ov_cnt = 8'h00;
      end else if (state_r.ov_cnt == OV_FILTER_CYC - 8'h01) begin
         state_nxt.ov_cnt    = OV_FILTER_CYC;
         state_nxt.ovp_latch = 1'b1;
      end else if (state_r.ov_cnt != OV_FILTER_CYC) begin
         state_nxt.ov_cnt = state_r.ov_cnt + 8'h01;
      end

      state_nxt.gfx_sd = state_nxt.ocp_latch | state_nxt.ovp_latch;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Per-phase gate drive, registered so outputs leave flip-flops
   genvar p;
   generate
      for (p = 0; p < NUM_PHASES; p++) begin : g_phase
         logic hs_cmd;
         // quick pulse overrides on-time of active phases
         // over-limit phase high side forced off
         assign hs_cmd = phase_active_i[p] & (quick_pulse_i | on_time_req_i[p]) &
                         ~over_limit_i[p];
      end
   endgenerate

   logic [NUM_PHASES-1:0] hs_cmd_all;
   generate
      for (p = 0; p < NUM_PHASES; p++) begin : g_collect
         assign hs_cmd_all[p] = g_phase[p].hs_cmd;
      end
   endgenerate

   state_t state_drv;

   // Gate overrides: over-voltage holds low sides on, over-current floats drives
   always_comb begin
      state_drv = state_nxt;
      if (state_nxt.ovp_latch) begin
         // high sides off, low sides on for active phases
         state_drv.hs = '0;
         state_drv.ls = phase_active_i;
      end else begin
         state_drv.hs = hs_cmd_all;
         state_drv.ls = phase_active_i & ~hs_cmd_all;
      end
      // latched over-current puts phase drives in high impedance
      state_drv.oe = state_nxt.ocp_latch ? '0 : phase_active_i;
      if (state_nxt.ocp_latch) begin
         state_drv.hs = '0;
         state_drv.ls = '0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // State register
   //
   // Synchronous reset returns every field to a constant. The bus answer
   // starts high so no access can complete during or right after reset.
   // Gates and drive enables reset low, so phases stay off until the
   // first clock after release fills them from the inputs.
   // The whole state moves on every edge; there is no enable.
   //
   always_ff @(posedge ref_clk_i) begin
      if (rst_i) begin
         state_r               <= '0;
         state_r.wait_b        <= 1'b1;
         state_r.zone          <= ZONE_RST;
         state_r.cur_code      <= CURRENT_RST;
         state_r.max_vcode     <= MAX_VOLTAGE_RST;
         state_r.alert_n       <= 1'b1;
      end else begin
         state_r <= state_drv;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs
   //
   // Every output below but the constant hot level leaves a flip-flop of the state, so the pins carry
   // no combinational path from the inputs. Gate and enable changes thus
   // appear one clock after the input that caused them.
   // The hot pin is open drain: the level is a constant zero and only the
   // enable moves, so the pin can never be driven high.
   //
   assign avs_readdata_o           = state_r.rdata;
   assign avs_waitrequest_o        = state_r.wait_b;
   assign alert_n_o                = state_r.alert_n;
   // open drain: drive zero only while asserted
   assign thermal_hot_n_o          = 1'b0;
   assign thermal_hot_oe_o         = state_r.hot;
   assign overcurrent_latch_o      = state_r.ocp_latch;
   assign overvoltage_latch_o      = state_r.ovp_latch;
   assign graphics_rail_shutdown_o = state_r.gfx_sd;
   assign high_side_gate_o         = state_r.hs;
   assign low_side_gate_o          = state_r.ls;
   assign phase_drive_oe_o         = state_r.oe;

endmodule

`default_nettype wire

// File: core_rail_fault_alert_checker.sv
// Port-level assertions for the core rail fault alert block
`timescale 1ns/1ps
`default_nettype none
module core_rail_fault_alert_checker #(
   parameter int NUM_PHASES = 3
) (
   input wire logic                  ref_clk_i,
   input wire logic                  rst_i,
   input wire logic                  avs_read_i,
   input wire logic                  avs_write_i,
   input wire logic                  avs_waitrequest_o,
   input wire logic [7:0]            temp_zone_code_i,
   input wire logic [NUM_PHASES-1:0] over_limit_i,
   input wire logic [NUM_PHASES-1:0] high_side_gate_o,
   input wire logic [NUM_PHASES-1:0] phase_drive_oe_o,
   input wire logic                  alert_n_o,
   input wire logic                  thermal_hot_n_o,
   input wire logic                  thermal_hot_oe_o,
   input wire logic                  overcurrent_latch_o,
   input wire logic                  overvoltage_latch_o,
   input wire logic                  graphics_rail_shutdown_o
);
   default clocking @(posedge ref_clk_i); endclocking
   default disable iff (rst_i);
   // Zone tripped, then release bit still set next sample
   sequence s_alert_held;
      temp_zone_code_i[6] ##1 temp_zone_code_i[5];
   endsequence
   sequence s_hot_held;
      temp_zone_code_i[7] ##1 temp_zone_code_i[6];
   endsequence
   ////////////////////////////////////////////////////////////////////////
   // alert and hot zone trips, gate drive and protection latches
   AST_THERM_SET: assert property (temp_zone_code_i[6] |=> !alert_n_o)
      else $error("attention not low after alert zone");
   AST_THERM_HOLD: assert property (s_alert_held |=> !alert_n_o)
      else $error("attention released while release bit held");
   AST_HOT_SET: assert property (temp_zone_code_i[7] |=> thermal_hot_oe_o)
      else $error("thermal hot not pulled after top zone");
   AST_HOT_HOLD: assert property (s_hot_held |=> thermal_hot_oe_o)
      else $error("thermal hot released too early");
   AST_HOT_REL: assert property ($fell(temp_zone_code_i[6]) && !temp_zone_code_i[7]
      |=> !thermal_hot_oe_o) else $error("thermal hot not released");
   AST_HOT_OD: assert property (thermal_hot_oe_o |-> !thermal_hot_n_o)
      else $error("thermal hot drives high");
   AST_GATE_OFF: assert property (|over_limit_i |=>
      (high_side_gate_o & $past(over_limit_i)) == '0) else $error("gate on over limit");
   AST_OCP_TRI: assert property (overcurrent_latch_o |->
      phase_drive_oe_o == '0 && high_side_gate_o == '0) else $error("drives on after latch");
   AST_GFX_SD: assert property ($rose(overcurrent_latch_o || overvoltage_latch_o)
      |-> ##[0:1] graphics_rail_shutdown_o) else $error("no graphics shutdown");
   AST_OV_HS: assert property (overvoltage_latch_o |=> high_side_gate_o == '0)
      else $error("high side on after over-voltage");
   // Bus answer comes one cycle after request, lasts one cycle
   AST_BUS_ANS: assert property ((avs_read_i || avs_write_i) && avs_waitrequest_o
      |=> !avs_waitrequest_o ##1 avs_waitrequest_o) else $error("bus answer timing");
endmodule
bind core_rail_fault_alert core_rail_fault_alert_checker #(.NUM_PHASES(NUM_PHASES)) chk (
   .ref_clk_i, .rst_i, .avs_read_i, .avs_write_i, .avs_waitrequest_o, .temp_zone_code_i,
   .over_limit_i, .high_side_gate_o, .phase_drive_oe_o, .alert_n_o, .thermal_hot_n_o,
   .thermal_hot_oe_o, .overcurrent_latch_o, .overvoltage_latch_o, .graphics_rail_shutdown_o);
`default_nettype wire

// File: core_rail_fault_alert_pkg.sv
// Constants shared by the core rail fault and alert block
package core_rail_fault_alert_pkg;

   // Avalon register byte offsets
   localparam logic [4:0] FAULT_STATUS_OFS   = 5'h00;
   localparam logic [4:0] LOAD_CURRENT_OFS   = 5'h04;
   localparam logic [4:0] TEMP_ZONE_OFS      = 5'h08;
   localparam logic [4:0] MAX_VOLTAGE_OFS    = 5'h0C;
   localparam logic [4:0] PROT_STATUS_OFS    = 5'h10;

   // Fault status field positions
   localparam int THERMAL_ALERT_BIT = 1;
   localparam int MAX_CURRENT_BIT   = 2;

   // Protection status field positions
   localparam int PROT_OCP_BIT      = 0;
   localparam int PROT_OVP_BIT      = 1;
   localparam int PROT_OFS_BIT      = 2;
   localparam int PROT_HOT_BIT      = 3;
   localparam int PROT_CNT_LSB      = 8;

   // Thermometer code bit positions
   localparam int ZONE_HOT_BIT      = 7;
   localparam int ZONE_ALERT_BIT    = 6;
   localparam int ZONE_RELEASE_BIT  = 5;

   // Load current thresholds
   localparam logic [7:0] CURRENT_FULL_SCALE = 8'hFF;
   localparam logic [7:0] CURRENT_RELEASE    = 8'hF2;

   // Reset values
   localparam logic [7:0] MAX_VOLTAGE_RST    = 8'h00;
   localparam logic [7:0] ZONE_RST           = 8'h00;
   localparam logic [7:0] CURRENT_RST        = 8'h00;

   // Over-current persistence in switching cycles
   localparam logic [3:0] OCP_CYCLES         = 4'hF;

   // Over-voltage margins in millivolts, code step in millivolts
   localparam int VCODE_STEP_MV     = 5;
   localparam int OV_MARGIN_MV      = 150;
   localparam int OV_MARGIN_OFS_MV  = 850;
   localparam logic [9:0] OV_MARGIN_CODES     = 10'(OV_MARGIN_MV / VCODE_STEP_MV);
   localparam logic [9:0] OV_MARGIN_OFS_CODES = 10'(OV_MARGIN_OFS_MV / VCODE_STEP_MV);

   // Over-voltage filter time and clock rate
   localparam int CLK_MHZ           = 200;
   localparam int OV_FILTER_NS      = 1000;
   localparam int OV_FILTER_CYC_INT = (OV_FILTER_NS * CLK_MHZ + 999) / 1000;
   localparam logic [7:0] OV_FILTER_CYC = 8'(OV_FILTER_CYC_INT);

endpackage

// File: host_bus_model.sv
// Host model issuing single register accesses on Avalon-MM
`timescale 1ns/1ps
`default_nettype none
module host_bus_model (
   input  wire logic        clk_i,
   input  wire logic        rst_i,
   input  wire logic        go_i,
   input  wire logic        wr_i,
   input  wire logic [4:0]  addr_i,
   input  wire logic [31:0] wdata_i,
   input  wire logic        waitrequest_i,
   input  wire logic [31:0] readdata_i,
   output var logic         read_o = 1'b0,
   output var logic         write_o = 1'b0,
   output var logic [4:0]   address_o = 5'h00,
   output var logic [31:0]  writedata_o = 32'h0,
   output var logic         done_o = 1'b0,
   output var logic [31:0]  rdata_o = 32'h0
);
   // Request held until waitrequest is low at an edge, no fixed latency
   always @(posedge clk_i) begin
      done_o <= 1'b0;
      if (rst_i) begin
         read_o <= 1'b0;
         write_o <= 1'b0;
      end else if ((read_o || write_o) && !waitrequest_i) begin
         read_o <= 1'b0;
         write_o <= 1'b0;
         done_o <= 1'b1;
         rdata_o <= readdata_i;
      end else if (go_i && !read_o && !write_o) begin
         read_o <= !wr_i;
         write_o <= wr_i;
         address_o <= addr_i;
         writedata_o <= wdata_i;
      end
   end
endmodule
`default_nettype wire

// File: test_core_rail_fault_alert.sv
// Self-checking bench for the core rail fault alert block
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, e) begin tests_run++; if ((a) !== (e)) begin fails++; \
   $display("[ERR] t=%0t got=%h exp=%h", $time, (a), (e)); end end
module test_core_rail_fault_alert;
   import core_rail_fault_alert_pkg::*;
   logic ref_clk_i = 1'b0, rst_i = 1'b1, go = 1'b0, wr = 1'b0, cv = 1'b0, sw = 1'b0, qp = 1'b0;
   logic ofs = 1'b0;
   logic [7:0]  tz = 8'h00, cc = 8'h00, vn = 8'h00;
   logic [2:0]  act = 3'h0, ont = 3'h0, ol = 3'h0, hs, ls, oe;
   logic [4:0]  addr = 5'h00, b_addr;
   logic [31:0] wd = 32'h0, rd, b_wd, b_rdd;
   logic        b_rd, b_wr, b_wq, done, al, hn, hoe, ocl, ovl, gfx;
   int          fails = 0, tests_run = 0;
   always #2.5 ref_clk_i = ~ref_clk_i;
   host_bus_model host (.clk_i(ref_clk_i), .rst_i(rst_i), .go_i(go), .wr_i(wr), .addr_i(addr),
      .wdata_i(wd), .waitrequest_i(b_wq), .readdata_i(b_rdd), .read_o(b_rd), .write_o(b_wr),
      .address_o(b_addr), .writedata_o(b_wd), .done_o(done), .rdata_o(rd));
   core_rail_fault_alert #(.NUM_PHASES(3)) dut (.ref_clk_i(ref_clk_i), .rst_i(rst_i),
      .avs_address_i(b_addr), .avs_read_i(b_rd), .avs_write_i(b_wr), .avs_writedata_i(b_wd),
      .avs_byteenable_i(4'hF), .avs_readdata_o(b_rdd), .avs_waitrequest_o(b_wq),
      .temp_zone_code_i(tz), .current_sample_valid_i(cv), .current_monitor_code_i(cc),
      .phase1_sense_neg_code_i(vn), .offset_pin_high_i(ofs), .switch_cycle_i(sw),
      .phase_active_i(act), .on_time_req_i(ont), .quick_pulse_i(qp), .over_limit_i(ol),
      .high_side_gate_o(hs), .low_side_gate_o(ls), .phase_drive_oe_o(oe), .alert_n_o(al),
      .thermal_hot_n_o(hn), .thermal_hot_oe_o(hoe), .overcurrent_latch_o(ocl),
      .overvoltage_latch_o(ovl), .graphics_rail_shutdown_o(gfx));
   ////////////////////////////////////////////////////////////////////////
   task automatic complete_run;
      if (fails == 0 && tests_run > 0) $display("RESULT: PASS");
      else $display("RESULT: FAIL");
      $finish;
   endtask
   // Settle outputs 1 ns past the edge so no race with the design
   task automatic cyc(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   // One bus access; only the bounded poll ends a stuck wait
   task automatic bus(input logic w, input logic [4:0] a, input logic [31:0] d);
      @(posedge ref_clk_i);
      go <= 1'b1;
      wr <= w;
      addr <= a;
      wd <= d;
      @(posedge ref_clk_i);
      go <= 1'b0;
      for (int i = 0; i < 20 && !done; i++) cyc(1);
      if (done !== 1'b1) begin
         fails++;
         complete_run();
      end
   endtask
   task automatic zone(input logic [7:0] v);
      @(posedge ref_clk_i) tz <= v;
      cyc(2);
   endtask
   task automatic sample(input logic [7:0] v);
      @(posedge ref_clk_i);
      cv <= 1'b1;
      cc <= v;
      @(posedge ref_clk_i) cv <= 1'b0;
      cyc(2);
   endtask
   task automatic tick;
      @(posedge ref_clk_i) sw <= 1'b1;
      @(posedge ref_clk_i) sw <= 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////////
   // Thermal alert and hot pin, both with hysteresis
   task automatic t_thermal;
      zone(8'h7F);
      `CHK({al, hoe}, 2'b00)
      bus(0, FAULT_STATUS_OFS, 0);
      `CHK(rd[2:1], 2'b01)
      bus(0, FAULT_STATUS_OFS, 0);
      `CHK(rd[2:1], 2'b01)
      zone(8'hFF);
      `CHK({hoe, hn}, 2'b10)
      zone(8'h7F);
      `CHK(hoe, 1'b1)
      zone(8'h3F);
      `CHK({al, hoe}, 2'b00)
      zone(8'h1F);
      `CHK(al, 1'b1)
      bus(0, FAULT_STATUS_OFS, 0);
      `CHK(rd[2:1], 2'b00)
   endtask
   // Full-scale current alert; sticky status needs release and a read
   task automatic t_current;
      sample(CURRENT_FULL_SCALE);
      `CHK(al, 1'b0)
      bus(0, FAULT_STATUS_OFS, 0);
      `CHK(rd[2:1], 2'b10)
      sample(8'hF3);
      `CHK(al, 1'b0)
      bus(0, FAULT_STATUS_OFS, 0);
      sample(8'hF2);
      `CHK(al, 1'b1)
      bus(0, FAULT_STATUS_OFS, 0);
      `CHK(rd[2:1], 2'b10)
      bus(0, FAULT_STATUS_OFS, 0);
      `CHK(rd[2:1], 2'b00)
      bus(0, LOAD_CURRENT_OFS, 0);
      `CHK(rd, 32'h000000F2)
   endtask
   // Quick pulse, per-phase limit, broken run, then a full run of 15
   task automatic t_ocp;
      @(posedge ref_clk_i);
      act <= 3'b011;
      qp <= 1'b1;
      cyc(2);
      `CHK(hs, 3'b011)
      @(posedge ref_clk_i) ol <= 3'b001;
      cyc(2);
      `CHK(hs, 3'b010)
      repeat (14) tick();
      @(posedge ref_clk_i) ol <= 3'b000;
      tick();
      @(posedge ref_clk_i) ol <= 3'b100;
      repeat (14) tick();
      cyc(2);
      `CHK(ocl, 1'b0)
      tick();
      cyc(2);
      `CHK({ocl, gfx, oe, hs}, 8'hC0)
      @(posedge ref_clk_i);
      ol <= 3'b000;
      qp <= 1'b0;
   endtask
   // Register write, unmapped read, over-voltage threshold and filter
   task automatic t_ovp;
      bus(1, MAX_VOLTAGE_OFS, 32'h40);
      bus(0, MAX_VOLTAGE_OFS, 0);
      `CHK(rd, 32'h00000040)
      bus(0, 5'h14, 32'h0);
      `CHK(rd, 32'h0)
      @(posedge ref_clk_i) vn <= 8'h40 + OV_MARGIN_CODES[7:0];
      cyc(250);
      `CHK(ovl, 1'b0)
      @(posedge ref_clk_i) vn <= 8'h41 + OV_MARGIN_CODES[7:0];
      cyc(198);
      `CHK(ovl, 1'b0)
      for (int i = 0; i < 6 && !ovl; i++) cyc(1);
      `CHK({ovl, gfx}, 2'b11)
      cyc(2);
      `CHK({hs, ls}, {3'b000, act})
   endtask
   // Offset strap high at reset release moves the over-voltage threshold
   task automatic t_ofs;
      bus(0, PROT_STATUS_OFS, 0);
      `CHK(rd[PROT_OFS_BIT], 1'b1)
      bus(1, MAX_VOLTAGE_OFS, 32'h40);
      @(posedge ref_clk_i) vn <= 8'h40 + OV_MARGIN_OFS_CODES[7:0];
      cyc(250);
      `CHK(ovl, 1'b0)
      @(posedge ref_clk_i) vn <= 8'h41 + OV_MARGIN_OFS_CODES[7:0];
      for (int i = 0; i < 210 && !ovl; i++) cyc(1);
      `CHK(ovl, 1'b1)
   endtask
   initial begin
      repeat (8) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_thermal();
      t_current();
      t_ocp();
      @(posedge ref_clk_i) rst_i <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_ovp();
      @(posedge ref_clk_i);
      rst_i <= 1'b1;
      ofs <= 1'b1;
      repeat (8) @(posedge ref_clk_i);
      rst_i <= 1'b0;
      t_ofs();
      complete_run();
   end
endmodule
`default_nettype wire
